/* File: logic/temp_monitor_defs.vh */
// Register offsets, field positions, reset values and timing of the monitor
`ifndef TEMP_MONITOR_DEFS_VH
`define TEMP_MONITOR_DEFS_VH

`define PTR_LOCAL_HIGH      8'h00
`define PTR_REMOTE1_HIGH    8'h01
`define PTR_REMOTE2_HIGH    8'h02
`define PTR_REMOTE3_HIGH    8'h03
`define PTR_CONV_STATE      8'h08
`define PTR_RUN_RANGE       8'h09
`define PTR_CHAN_ENABLE     8'h0A
`define PTR_SEQ_RATE        8'h0B
`define PTR_ONE_SHOT        8'h0F
`define PTR_LOCAL_LOW       8'h10
`define PTR_REMOTE1_LOW     8'h11
`define PTR_REMOTE2_LOW     8'h12
`define PTR_REMOTE3_LOW     8'h13

`define HIGH_BASE_MASK      8'hFC
`define HIGH_BASE           8'h00
`define LOW_BASE            8'h10

`define BIT_CONV_ACTIVE     7
`define BIT_STOP_REQUEST    6
`define BIT_RANGE           2
`define BIT_RES_CANCEL      2
`define BIT_LOCAL_EN        3
`define BIT_REMOTE1_EN      4
`define BIT_REMOTE2_EN      5
`define BIT_REMOTE3_EN      6

`define RUN_RANGE_MASK      8'h44
`define CHAN_EN_MASK_BASE   8'h1C
`define CHAN_EN_MASK_REM2   8'h20
`define CHAN_EN_MASK_REM3   8'h40
`define SEQ_RATE_MASK       8'h07

`define RESET_POINTER       8'h00
`define RESET_RESULT        8'h00
`define RESET_RUN_RANGE     8'h00
`define RESET_SEQ_RATE      8'h07

`define CLK_HZ              40000000
`define FASTEST_SEQ_PER_SEC 8
`define RATE_CODE_FASTEST   3'h7

`endif

/* File: logic/seq_rate_timer.v */
// Period timer that paces conversion sequences by the rate code
`timescale 1ns/1ps
`default_nettype none
`include "temp_monitor_defs.vh"

module seq_rate_timer #(
	parameter FAST_PERIOD = `CLK_HZ / `FASTEST_SEQ_PER_SEC
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        restart,
	input  wire [2:0]  rate_select,
	output reg         expired
);

	reg  [31:0] count_reg;
	wire [31:0] limit;
	wire [2:0]  shift_amt;

	// Each code step down doubles the sequence period
	assign shift_amt = `RATE_CODE_FASTEST - rate_select;
	assign limit     = FAST_PERIOD[31:0] << shift_amt;

	// Measured from sequence start, so a long sequence caps the rate
	always @(posedge clk)
	begin
		if (sys_rst || restart)
		begin
			count_reg <= 32'h0000_0000;
			expired   <= 1'b0;
		end
		else
		begin
			if (count_reg < limit)
				count_reg <= count_reg + 32'h0000_0001;
			// Expired flag, idle decode and restart cost three cycles; keep FAST_PERIOD above 3
			expired <= (count_reg >= limit - 32'h0000_0003);
		end
	end

endmodule // seq_rate_timer
`default_nettype wire

/* File: logic/two_wire_target.v */
// Two-wire bus target: address match, pointer and data bytes, read bytes
`timescale 1ns/1ps
`default_nettype none

module two_wire_target #(
	parameter [6:0] BUS_ADDR = 7'h2A
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        scl_i,
	input  wire        sda_i,
	output reg         sda_o,
	output reg         sda_oe,
	output reg         ptr_wr,
	output reg         data_wr,
	output reg  [7:0]  wr_byte,
	output reg         rd_req,
	output reg         rd_seq,
	input  wire [7:0]  rd_byte
);

	localparam S_IDLE = 3'd0;
	localparam S_ADDR = 3'd1;
	localparam S_AACK = 3'd2;
	localparam S_WR   = 3'd3;
	localparam S_WACK = 3'd4;
	localparam S_RD   = 3'd5;
	localparam S_RACK = 3'd6;

	reg [2:0] scl_sync;
	reg [2:0] sda_sync;
	reg [2:0] state_reg;
	reg [3:0] cnt_reg;
	reg [7:0] shift_reg;
	reg [7:0] tx_reg;
	reg       rw_reg;
	reg       first_reg;
	reg       acked_reg;

	wire scl_rise = scl_sync[1] & ~scl_sync[2];
	wire scl_fall = ~scl_sync[1] & scl_sync[2];
	wire start_c  = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
	wire stop_c   = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			scl_sync  <= 3'h7;
			sda_sync  <= 3'h7;
			state_reg <= S_IDLE;
			cnt_reg   <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg    <= 8'h00;
			rw_reg    <= 1'b0;
			first_reg <= 1'b1;
			acked_reg <= 1'b0;
			sda_o     <= 1'b0;
			sda_oe    <= 1'b0;
			ptr_wr    <= 1'b0;
			data_wr   <= 1'b0;
			wr_byte   <= 8'h00;
			rd_req    <= 1'b0;
			rd_seq    <= 1'b0;
		end
		else
		begin
			scl_sync <= {scl_sync[1:0], scl_i};
			sda_sync <= {sda_sync[1:0], sda_i};
			ptr_wr   <= 1'b0;
			data_wr  <= 1'b0;
			rd_req   <= 1'b0;
			if (start_c)
			begin
				state_reg <= S_ADDR;
				cnt_reg   <= 4'h0;
				first_reg <= 1'b1;
				sda_oe    <= 1'b0;
			end
			else if (stop_c)
			begin
				state_reg <= S_IDLE;
				sda_oe    <= 1'b0;
			end
			else if (scl_rise)
			begin
				case (state_reg)
					S_ADDR, S_WR:
					begin
						shift_reg <= {shift_reg[6:0], sda_sync[1]};
						cnt_reg   <= cnt_reg + 4'h1;
					end
					S_AACK:
					begin
						// Ask for the byte early; it is ready by the falling edge
						if (rw_reg)
						begin
							rd_req <= 1'b1;
							rd_seq <= 1'b0;
						end
					end
					S_RACK:
					begin
						acked_reg <= ~sda_sync[1];
						if (!sda_sync[1])
						begin
							rd_req <= 1'b1;
							rd_seq <= 1'b1;
						end
					end
					default:
					begin
					end
				endcase
			end
			else if (scl_fall)
			begin
				case (state_reg)
					S_ADDR:
					begin
						if (cnt_reg == 4'h8)
						begin
							if (shift_reg[7:1] == BUS_ADDR)
							begin
								rw_reg    <= shift_reg[0];
								sda_oe    <= 1'b1;
								state_reg <= S_AACK;
							end
							else
								state_reg <= S_IDLE;
						end
					end
					S_AACK:
					begin
						if (rw_reg)
						begin
							tx_reg    <= rd_byte;
							sda_oe    <= ~rd_byte[7];
							cnt_reg   <= 4'h1;
							state_reg <= S_RD;
						end
						else
						begin
							sda_oe    <= 1'b0;
							cnt_reg   <= 4'h0;
							state_reg <= S_WR;
						end
					end
					S_WR:
					begin
						if (cnt_reg == 4'h8)
						begin
							sda_oe    <= 1'b1;
							wr_byte   <= shift_reg;
							ptr_wr    <= first_reg;
							data_wr   <= ~first_reg;
							first_reg <= 1'b0;
							state_reg <= S_WACK;
						end
					end
					S_WACK:
					begin
						sda_oe    <= 1'b0;
						cnt_reg   <= 4'h0;
						state_reg <= S_WR;
					end
					S_RD:
					begin
						if (cnt_reg == 4'h8)
						begin
							sda_oe    <= 1'b0;
							state_reg <= S_RACK;
						end
						else
						begin
							sda_oe  <= ~tx_reg[3'h7 - cnt_reg[2:0]];
							cnt_reg <= cnt_reg + 4'h1;
						end
					end
					S_RACK:
					begin
						if (acked_reg)
						begin
							tx_reg    <= rd_byte;
							sda_oe    <= ~rd_byte[7];
							cnt_reg   <= 4'h1;
							state_reg <= S_RD;
						end
						else
							state_reg <= S_IDLE;
					end
					default:
					begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule // two_wire_target
`default_nettype wire

/* File: logic/temp_result_config_sequencer.v */
// Register file, read coherence and channel sequencer of the monitor
//
// Contract
// - Local and remote1 bytes at 00h/10h, 01h/11h
// - Remote2 at 02h/12h, remote3 at 03h/13h
// - Results read-only, reloaded per finished measurement
// - Low byte matches preceding high byte read
// - Two-byte read gives high then coherent low
// - Result registers reset to zero
// - Status 08h: bit7 conversion active, rest zero
// - First conversion starts automatically after power-up
// - Stop request clear: convert continuously at rate
// - Stop set: finish sequence, shut down; resume
// - One-shot in shutdown runs one sequence
// - Range bit selects standard or extended format
// - Bit 3 of 0Ah enables local channel
// - Bits 4-6 of 0Ah enable remote channels
// - Bit 2 of 0Ah enables series-resistance correction
// - Channel enable reset values depend on variant
// - Sequence order local, remote1..3, then idle
// - Disabled channels are skipped
// - Rate register changes only idle time
// - One-shot during idle starts sequence at once
// - Rate codes 0..7 give 1/16 to 8 per second
// - One-shot during conversion is ignored
// - Every write loads pointer; pointer resets zero
// - High byte integer degrees, low byte fraction
`timescale 1ns/1ps
`default_nettype none
`include "temp_monitor_defs.vh"

module temp_result_config_sequencer #(
	parameter       NUM_REMOTE  = 3,
	parameter [6:0] BUS_ADDR    = 7'h2A,
	parameter       FAST_PERIOD = `CLK_HZ / `FASTEST_SEQ_PER_SEC
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        scl_i,
	input  wire        sda_i,
	output wire        sda_o,
	output wire        sda_oe,
	output reg         meas_start,
	output reg  [1:0]  meas_chan,
	output reg         meas_range,
	output reg         meas_res_cancel,
	output reg         conv_active,
	input  wire        meas_done,
	input  wire [7:0]  meas_high,
	input  wire [7:0]  meas_low
);

	localparam ST_SHUT = 2'd0;
	localparam ST_PICK = 2'd1;
	localparam ST_WAIT = 2'd2;
	localparam ST_IDLE = 2'd3;

	// Only bit 2 and the enable bits of channels that exist can be written or read back
	localparam [7:0] CHAN_EN_MASK = `CHAN_EN_MASK_BASE
		| ((NUM_REMOTE >= 2) ? `CHAN_EN_MASK_REM2 : 8'h00)
		| ((NUM_REMOTE >= 3) ? `CHAN_EN_MASK_REM3 : 8'h00);

	////////////////////////////////////////////////////////////////////////

	wire       ptr_wr;
	wire       data_wr;
	wire [7:0] wr_byte;
	wire       rd_req;
	wire       rd_seq;
	wire       rate_expired;

	reg  [7:0] pointer_reg;
	reg  [7:0] run_range_reg;
	reg  [7:0] chan_en_reg;
	reg  [7:0] seq_rate_reg;
	reg  [7:0] res_hi [0:3];
	reg  [7:0] res_lo [0:3];
	reg  [7:0] snap_lo_reg;
	reg  [1:0] snap_chan_reg;
	reg        snap_valid_reg;
	reg  [7:0] rd_byte_reg;
	reg  [1:0] state_reg;
	reg  [2:0] chan_reg;
	reg        timer_restart;
	reg        one_shot;

	wire [3:0] chan_enables;
	wire       stop_request;
	wire       is_high_ptr;
	wire       is_low_ptr;
	wire [1:0] ptr_chan;

	assign stop_request = run_range_reg[`BIT_STOP_REQUEST];
	assign chan_enables = {chan_en_reg[`BIT_REMOTE3_EN],
		chan_en_reg[`BIT_REMOTE2_EN], chan_en_reg[`BIT_REMOTE1_EN],
		chan_en_reg[`BIT_LOCAL_EN]};
	assign is_high_ptr  = (pointer_reg & `HIGH_BASE_MASK) == `HIGH_BASE;
	assign is_low_ptr   = (pointer_reg & `HIGH_BASE_MASK) == `LOW_BASE;
	assign ptr_chan     = pointer_reg[1:0];

	////////////////////////////////////////////////////////////////////////

	two_wire_target #(
		.BUS_ADDR (BUS_ADDR)
	) u_bus (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.scl_i    (scl_i),
		.sda_i    (sda_i),
		.sda_o    (sda_o),
		.sda_oe   (sda_oe),
		.ptr_wr   (ptr_wr),
		.data_wr  (data_wr),
		.wr_byte  (wr_byte),
		.rd_req   (rd_req),
		.rd_seq   (rd_seq),
		.rd_byte  (rd_byte_reg)
	);

	seq_rate_timer #(
		.FAST_PERIOD (FAST_PERIOD)
	) u_rate (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.restart     (timer_restart),
		.rate_select (seq_rate_reg[2:0]),
		.expired     (rate_expired)
	);

	////////////////////////////////////////////////////////////////////////
	// Pointer and writable registers

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			pointer_reg   <= `RESET_POINTER;
			run_range_reg <= `RESET_RUN_RANGE;
			chan_en_reg   <= CHAN_EN_MASK;
			seq_rate_reg  <= `RESET_SEQ_RATE;
			one_shot      <= 1'b0;
		end
		else
		begin
			one_shot <= 1'b0;
			if (ptr_wr)
				pointer_reg <= wr_byte;
			if (data_wr)
			begin
				// Reserved bits are dropped rather than stored
				case (pointer_reg)
					`PTR_RUN_RANGE:
						run_range_reg <= wr_byte & `RUN_RANGE_MASK;
					`PTR_CHAN_ENABLE:
						chan_en_reg <= wr_byte & CHAN_EN_MASK;
					`PTR_SEQ_RATE:
						seq_rate_reg <= wr_byte & `SEQ_RATE_MASK;
					`PTR_ONE_SHOT:
						one_shot <= 1'b1;
					default:
					begin
						// Result and status writes have no effect
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result storage, one entry per channel

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_result
			always @(posedge clk)
			begin
				if (sys_rst)
				begin
					res_hi[gi] <= `RESET_RESULT;
					res_lo[gi] <= `RESET_RESULT;
				end
				else if (state_reg == ST_WAIT && meas_done &&
					meas_chan == gi)
				begin
					// Front end delivers bytes in the selected format
					res_hi[gi] <= meas_high;
					res_lo[gi] <= meas_low;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read path with low-byte snapshot

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			rd_byte_reg    <= 8'h00;
			snap_lo_reg    <= 8'h00;
			snap_chan_reg  <= 2'h0;
			snap_valid_reg <= 1'b0;
		end
		else if (rd_req)
		begin
			snap_valid_reg <= 1'b0;
			if (rd_seq && is_high_ptr)
			begin
				// Second byte of a burst from a high pointer
				rd_byte_reg <= snap_lo_reg;
			end
			else if (is_high_ptr)
			begin
				rd_byte_reg    <= res_hi[ptr_chan];
				snap_lo_reg    <= res_lo[ptr_chan];
				snap_chan_reg  <= ptr_chan;
				snap_valid_reg <= 1'b1;
			end
			else if (is_low_ptr)
			begin
				if (snap_valid_reg && snap_chan_reg == ptr_chan)
					rd_byte_reg <= snap_lo_reg;
				else
					rd_byte_reg <= res_lo[ptr_chan];
			end
			else
			begin
				case (pointer_reg)
					`PTR_CONV_STATE:
						rd_byte_reg <= {conv_active, 7'h00};
					`PTR_RUN_RANGE:
						rd_byte_reg <= run_range_reg;
					`PTR_CHAN_ENABLE:
						rd_byte_reg <= chan_en_reg;
					`PTR_SEQ_RATE:
						rd_byte_reg <= seq_rate_reg;
					default:
						rd_byte_reg <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	// First enabled channel at or after the current index; bit 2 = none
	function [2:0] next_enabled;
		input [2:0] from;
		input [3:0] en;
		integer     k;
		begin
			next_enabled = 3'h4;
			for (k = 3; k >= 0; k = k - 1)
				if (k >= from && en[k])
					next_enabled = k[2:0];
		end
	endfunction

	wire [2:0] pick = next_enabled(chan_reg, chan_enables);

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			// Reset lands in the pick state: conversion begins at once
			state_reg       <= ST_PICK;
			chan_reg        <= 3'h0;
			timer_restart   <= 1'b1;
			meas_start      <= 1'b0;
			meas_chan       <= 2'h0;
			meas_range      <= 1'b0;
			meas_res_cancel <= 1'b0;
			conv_active     <= 1'b0;
		end
		else
		begin
			timer_restart   <= 1'b0;
			meas_start      <= 1'b0;
			meas_range      <= run_range_reg[`BIT_RANGE];
			meas_res_cancel <= chan_en_reg[`BIT_RES_CANCEL];
			case (state_reg)
				ST_PICK:
				begin
					if (!pick[2])
					begin
						meas_start  <= 1'b1;
						meas_chan   <= pick[1:0];
						chan_reg    <= pick;
						conv_active <= 1'b1;
						state_reg   <= ST_WAIT;
					end
					else
					begin
						conv_active <= 1'b0;
						if (stop_request)
							state_reg <= ST_SHUT;
						else
							state_reg <= ST_IDLE;
					end
				end
				ST_WAIT:
				begin
					// One-shot writes here fall through unused
					if (meas_done)
					begin
						chan_reg  <= chan_reg + 3'h1;
						state_reg <= ST_PICK;
					end
				end
				ST_IDLE:
				begin
					if (stop_request)
						state_reg <= ST_SHUT;
					else if (one_shot || rate_expired)
					begin
						// Rate only gates this wait
						chan_reg      <= 3'h0;
						timer_restart <= 1'b1;
						state_reg     <= ST_PICK;
					end
				end
				ST_SHUT:
				begin
					if (one_shot || !stop_request)
					begin
						// After a one-shot stop stays set, so it returns here
						chan_reg      <= 3'h0;
						timer_restart <= 1'b1;
						state_reg     <= ST_PICK;
					end
				end
				default:
					state_reg <= ST_SHUT;
			endcase
		end
	end

endmodule // temp_result_config_sequencer
`default_nettype wire

/* File: test/temp_result_config_sequencer_asserts.sv */
// Checker for the measurement handshake and open-drain pin of the monitor
`timescale 1ns/1ps
`default_nettype none
module seq_checker (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       sda_o,
	input wire logic       meas_start,
	input wire logic [1:0] meas_chan,
	input wire logic       conv_active,
	input wire logic       meas_done
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	reg [1:0] last_ch_reg;
	reg       seen_reg;
	// Remembers the previous channel of the sequence now running
	always @(posedge clk)
	begin
		if (sys_rst || !conv_active)
			seen_reg <= 1'b0;
		else if (meas_start)
			seen_reg <= 1'b1;
		if (meas_start)
			last_ch_reg <= meas_chan;
	end
	////////////////////////////////////////
	sequence s_first;
		meas_start && conv_active && meas_chan == 2'h0;
	endsequence
	sequence s_pick;
		##2 (meas_start || !conv_active);
	endsequence
	property p_start_active;
		meas_start |-> conv_active;
	endproperty
	property p_start_gap;
		meas_start |=> !meas_start [*2];
	endproperty
	property p_done_next;
		meas_done |-> s_pick;
	endproperty
	property p_chan_hold;
		!meas_start |-> $stable(meas_chan);
	endproperty
	property p_chan_order;
		meas_start && seen_reg |-> meas_chan > last_ch_reg;
	endproperty
	property p_open_drain;
		sda_o == 1'b0;
	endproperty
	property p_first_conv;
		$fell(sys_rst) |-> ##[1:2] s_first;
	endproperty
	property p_fall_done;
		$fell(conv_active) |-> $past(meas_done, 2);
	endproperty
	a_start_active: assert property (p_start_active)
		else $error("measurement started while status idle");
	a_start_gap: assert property (p_start_gap)
		else $error("measurement starts too close");
	a_done_next: assert property (p_done_next)
		else $error("no next channel two cycles after done");
	a_chan_hold: assert property (p_chan_hold)
		else $error("channel changed without a start");
	a_chan_order: assert property (p_chan_order)
		else $error("channel order not ascending");
	a_open_drain: assert property (p_open_drain)
		else $error("data pin driven high");
	a_first_conv: assert property (p_first_conv)
		else $error("no conversion after reset");
	a_fall_done: assert property (p_fall_done)
		else $error("busy dropped without a finished channel");
endmodule // seq_checker
bind temp_result_config_sequencer seq_checker i_chk (
	.clk(clk), .sys_rst(sys_rst), .sda_o(sda_o), .meas_start(meas_start),
	.meas_chan(meas_chan), .conv_active(conv_active), .meas_done(meas_done)
);
`default_nettype wire

/* File: test/bus_host_model.sv */
// Behavioural two-wire bus host that sets the pointer, writes and reads
`timescale 1ns/1ps
`default_nettype none
module bus_host_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input  wire logic       clk,
	input  wire logic       sda_line,
	output var  logic       scl,
	output var  logic       sda_pull,
	output var  logic       rd_valid,
	output var  logic [7:0] rd_data,
	output var  logic [7:0] nack_cnt
);
	// Bus idles released with the clock line high
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
		nack_cnt = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Data moves mid-way through SCL low so both phases last 8 clocks
	task automatic put_bit(input logic b);
		sda_pull = !b;
		tick(4);
		scl = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(4);
	endtask
	task automatic get_bit(output logic b);
		sda_pull = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		b = sda_line;
		tick(4);
		scl = 1'b0;
		tick(4);
	endtask
	task automatic put_byte(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--)
			put_bit(v[i]);
		get_bit(a);
		if (a)
			nack_cnt++;
	endtask
	task automatic write(input logic [7:0] p, d, input bit has_d);
		sda_pull = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(4);
		put_byte({ADDR, 1'b0});
		put_byte(p);
		if (has_d)
			put_byte(d);
		sda_pull = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b0;
		tick(8);
	endtask
	// Only sets the pointer to 00h; read_raw reads from the pointer that the last write left, NACK ends the burst
	task automatic read(input int n);
		logic [7:0] v;
		write(8'h00, 8'h00, 1'b0);
		tick(0);
	endtask
	task automatic read_raw(input int n);
		logic [7:0] v;
		sda_pull = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(4);
		put_byte({ADDR, 1'b1});
		for (int k = 0; k < n; k++)
		begin
			for (int i = 7; i >= 0; i--)
				get_bit(v[i]);
			rd_data = v;
			rd_valid = 1'b1;
			tick(1);
			rd_valid = 1'b0;
			put_bit(k == n - 1);
		end
		sda_pull = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b0;
		tick(8);
	endtask
endmodule // bus_host_model
`default_nettype wire

/* File: test/temp_result_config_sequencer_tb.sv */
// Self-checking bench for the monitor's registers and sequencer
`timescale 1ns/1ps
`default_nettype none
module temp_result_config_sequencer_tb;
	localparam int FP = 200;
	logic       clk;
	logic       sys_rst;
	logic       meas_done;
	logic [7:0] meas_high;
	logic [7:0] meas_low;
	logic [7:0] hi_m [4] = '{default: 8'h00};
	logic [7:0] lo_m [4] = '{default: 8'h00};
	logic [7:0] exp_q [$];
	logic [3:0] ens = 4'hF;
	logic       rc_m = 1'b1;
	logic       rng_m = 1'b0;
	logic       hold = 1'b1;
	logic       in_seq = 1'b0;
	logic [1:0] last_ch = 2'h0;
	int         n_starts = 0;
	int         error_cnt = 0;
	int         num_checks = 0;
	wire logic  scl, sda_pull, rd_valid, sda_o, sda_oe, meas_start;
	wire logic  meas_range, meas_res_cancel, conv_active;
	wire logic [1:0] meas_chan;
	wire logic [7:0] rd_data, nack_cnt;
	wire logic  sda_line = !(sda_pull | sda_oe);
	temp_result_config_sequencer #(.FAST_PERIOD(FP)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe(sda_oe), .meas_start(meas_start),
		.meas_chan(meas_chan), .meas_range(meas_range),
		.meas_res_cancel(meas_res_cancel), .conv_active(conv_active),
		.meas_done(meas_done), .meas_high(meas_high), .meas_low(meas_low));
	bus_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl),
		.sda_pull(sda_pull), .rd_valid(rd_valid), .rd_data(rd_data),
		.nack_cnt(nack_cnt));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = !clk;
	end
	////////////////////////////////////////
	task automatic cmp_byte(input logic [7:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_cnt(input int e, g);
		num_checks++;
		if (g != e)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] p, e0, e1, input int n);
		exp_q.push_back(e0);
		if (n > 1)
			exp_q.push_back(e1);
		i_host.write(p, 8'h00, 1'b0);
		i_host.read_raw(n);
	endtask
	task automatic wait_act(input logic v, input int lim);
		for (int k = 0; k < lim && conv_active !== v; k++)
			i_host.tick(1);
		cmp_byte({7'h0, v}, {7'h0, conv_active});
	endtask
	function automatic logic [1:0] next_ch();
		for (int i = 0; i < 4; i++)
			if (ens[i] && (!in_seq || i > last_ch))
				return i[1:0];
		return 2'h0;
	endfunction
	always @(posedge clk)
	begin
		if (rd_valid === 1'b1)
			cmp_byte(exp_q.size() ? exp_q.pop_front() : 8'hXX, rd_data);
	end
	// Front end: answers each start after a random delay with random bytes
	initial
	begin
		meas_done = 1'b0;
		meas_high = 8'h00;
		meas_low = 8'h00;
		forever
		begin
			i_host.tick(1);
			if (conv_active !== 1'b1)
				in_seq = 1'b0;
			if (meas_start === 1'b1)
			begin
				n_starts++;
				cmp_byte({6'h0, next_ch()}, {6'h0, meas_chan});
				cmp_byte({6'h0, rc_m, rng_m}, {6'h0, meas_res_cancel, meas_range});
				in_seq = 1'b1;
				last_ch = meas_chan;
				wait (!hold);
				i_host.tick(2 + $urandom_range(15));
				meas_high = $urandom;
				meas_low = $urandom;
				meas_done = 1'b1;
				hi_m[meas_chan] = meas_high;
				lo_m[meas_chan] = meas_low;
				i_host.tick(1);
				meas_done = 1'b0;
			end
		end
	end
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		// Roughly twice the expected length of all tests
		repeat (90000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
	////////////////////////////////////////
	initial
	begin
		logic [7:0] v;
		int         c;
		int         n0;
		sys_rst = 1'b1;
		void'($urandom(20));
		i_host.tick(10);
		sys_rst = 1'b0;
		i_host.tick(4);
		rd(8'h09, 8'h00, 8'h00, 1);
		rd(8'h0A, 8'h7C, 8'h00, 1);
		rd(8'h08, 8'h80, 8'h00, 1);
		for (int i = 0; i < 4; i++)
			rd(i[7:0], 8'h00, 8'h00, 2);
		hold = 1'b0;
		$display("test reset_values done");
		rd(8'h0B, 8'h07, 8'h00, 1);
		for (int i = 0; i < 8; i++)
		begin
			v = $urandom;
			i_host.write(8'h0B, {v[7:3], i[2:0]}, 1'b1);
			rd(8'h0B, {5'h00, i[2:0]}, 8'h00, 1);
		end
		for (int i = 7; i > 4; i--)
		begin
			i_host.write(8'h0B, i[7:0], 1'b1);
			wait_act(1'b0, 2000);
			wait_act(1'b1, 30000);
			for (c = 0; conv_active === 1'b1 && c < 30000; c++)
				i_host.tick(1);
			for (; conv_active !== 1'b1 && c < 30000; c++)
				i_host.tick(1);
			cmp_cnt(FP << (7 - i), c);
		end
		$display("test rate done");
		i_host.write(8'h0B, 8'h00, 1'b1);
		wait_act(1'b0, 2000);
		n0 = n_starts;
		i_host.write(8'h0F, 8'h00, 1'b1);
		i_host.tick(300);
		cmp_cnt(4, n_starts - n0);
		i_host.write(8'h0B, 8'h07, 1'b1);
		i_host.write(8'h09, 8'h40, 1'b1);
		wait_act(1'b0, 2000);
		n0 = n_starts;
		i_host.tick(1000);
		cmp_cnt(0, n_starts - n0);
		$display("test oneshot_shutdown done");
		i_host.write(8'h09, 8'h44, 1'b1);
		rng_m = 1'b1;
		rd(8'h09, 8'h44, 8'h00, 1);
		i_host.write(8'h0A, 8'hFF, 1'b1);
		rd(8'h0A, 8'h7C, 8'h00, 1);
		i_host.write(8'h00, 8'hA5, 1'b1);
		i_host.write(8'h08, 8'hA5, 1'b1);
		rd(8'h00, hi_m[0], 8'h00, 1);
		rd(8'h08, 8'h00, 8'h00, 1);
		rd(8'h30, 8'h00, 8'h00, 1);
		$display("test registers done");
		for (int j = 0; j < 4; j++)
		begin
			v = $urandom;
			ens = v[6:3] | (4'h1 << v[1:0]);
			rc_m = v[2];
			rng_m = v[7];
			i_host.write(8'h0A, {1'b0, ens, rc_m, 2'h0}, 1'b1);
			i_host.write(8'h09, {5'h08, rng_m, 2'h0}, 1'b1);
			n0 = n_starts;
			i_host.write(8'h0F, v, 1'b1);
			i_host.tick(300);
			cmp_cnt($countones(ens), n_starts - n0);
			for (int i = 0; i < 4; i++)
				rd(i[7:0], hi_m[i], lo_m[i], 2);
		end
		$display("test enables done");
		rd(8'h01, hi_m[1], 8'h00, 1);
		v = lo_m[1];
		ens = 4'hF;
		rc_m = 1'b1;
		i_host.write(8'h0A, 8'h7C, 1'b1);
		i_host.write(8'h0F, 8'h00, 1'b1);
		i_host.tick(300);
		rd(8'h11, v, 8'h00, 1);
		rd(8'h01, hi_m[1], 8'h00, 1);
		rd(8'h10, lo_m[0], 8'h00, 1);
		rng_m = 1'b0;
		i_host.write(8'h09, 8'h00, 1'b1);
		wait_act(1'b1, 1000);
		cmp_byte(8'h00, nack_cnt);
		$display("test coherence_resume done");
		wrap_up();
	end
endmodule // temp_result_config_sequencer_tb
`default_nettype wire
